// [src/flex_line_pkg.sv]
// Purpose: shared constants for the flexible line configuration block
// Assumes: register addresses are the printed word addresses of the access protocol
// Notes: lines 4 to 11 exist; bulk bit positions equal the channel number
package flex_line_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int FIRST_LINE = 4;
    localparam int LAST_LINE = 11;
    localparam int LINE_COUNT = 8;
    localparam int PULLUP_BITS = 12;
    localparam logic [15:0] ADDR_SINGLE = 16'h07d4;
    localparam logic [15:0] ADDR_ANALOG = 16'h0008;
    localparam logic [15:0] STRIDE_SINGLE = 16'h0001;
    localparam logic [15:0] STRIDE_ANALOG = 16'h0002;
    localparam logic [15:0] ADDR_STATE = 16'h0af0;
    localparam logic [15:0] ADDR_DIRECTION = 16'h0b22;
    localparam logic [15:0] ADDR_ANALOG_SELECT = 16'h0b40;
    localparam logic [15:0] ADDR_PULLUP_OFF = 16'h0b4a;
    localparam logic [15:0] ADDR_WRITE_BLOCK = 16'h0b54;
    localparam logic [31:0] WRITE_BLOCK_RESET = 32'h0000_0000;
    localparam logic [7:0] LINES_RESET = 8'h00;
    localparam logic [11:0] PULLUP_RESET = 12'h000;
    localparam logic [3:0] NO_LINE = 4'h0;
endpackage

// [src/pin_sync.sv]
// Purpose: two-flop synchroniser for the line pins
// Assumes: pins change with no relation to clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = flex_line_pkg::LINE_COUNT
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage <= '0;
            synced <= '0;
        end else begin
            stage <= pin;
            synced <= stage;
        end
    end
endmodule

// [src/flexible_io_line_config.sv]
// Purpose: register access and line configuration for eight flexible lines
// Assumes: register port and converter run on clock; pins are asynchronous
// Notes: analog conversion itself lives outside; its result arrives on adc_value
// Function
// RULE1 - reading a line's single register makes it a digital input and returns its level.
// RULE2 - writing a line's single register makes a digital line an output driving the bit.
// RULE3 - a single-register write to an analog line is dropped and the line stays analog.
// RULE4 - reading a line's analog register puts it in analog mode before the value returns; the code sets the analog bit on the same edge that returns adc_value.
// RULE5 - eight 16-bit single registers sit at consecutive addresses for channels 4 to 11.
// RULE6 - a set write-block bit stops state, direction and analog-select writes on that line.
// RULE7 - analog-select bit 1 is analog, 0 digital, and leaving analog makes the line an input.
// RULE8 - the bulk direction register holds 0 for input and 1 for output, masked per bit.
// RULE9 - bulk state writes levels without touching direction and reads the sensed pins.
// RULE10 - in each bulk register a line's bit position equals its channel number.
// RULE11 - a set pull-up-off bit keeps the pull-up off on that line while it is an input.
// RULE12 - pull-up-off writes land on every bit whatever the write-block mask holds.
// RULE13 - the host forces an analog line to output by reading then writing its single register.
// RULE14 - the host sets up inputs by clearing block, analog and direction bits, then reading.
// RULE15 - the host sets up outputs by clearing block and analog bits, setting direction, writing.
// RULE16 - the host sets up analog inputs by clearing block bits, setting analog bits, reading.
// RULE17 - a bulk write updates all unblocked bits in one access and leaves blocked bits alone.
`timescale 1ns/1ps
module flexible_io_line_config (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [31:0] adc_value,
    output logic [3:0] adc_channel,
    output logic adc_start,
    input wire logic [11:4] line_in,
    output logic [11:4] line_out,
    output logic [11:4] line_oe,
    output logic [11:4] pullup_en
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [11:4] analog;
    logic [11:4] dir;
    logic [11:4] level;
    logic [11:0] pullup_off;
    logic [31:0] write_block;
    logic [11:4] line_sync;
    logic [11:4] next_analog;
    logic [11:4] next_dir;
    logic [11:4] next_level;
    logic [11:0] next_pullup_off;
    logic [31:0] next_write_block;
    logic [31:0] next_rdata;
    logic next_rvalid;
    logic [3:0] next_adc_channel;
    logic next_adc_start;
    logic [11:4] allow;
    logic [3:0] single_line;
    logic [3:0] analog_line;
    logic rd_only;

    // returns the channel whose register sits at addr, or NO_LINE
    function automatic logic [3:0] line_of(input logic [15:0] addr, input logic [15:0] base,
                                           input logic [15:0] stride);
        logic [3:0] hit;
        hit = flex_line_pkg::NO_LINE;
        for (int k = flex_line_pkg::FIRST_LINE; k <= flex_line_pkg::LAST_LINE; k++) begin
            if (addr == 16'(base + stride * 16'(k - flex_line_pkg::FIRST_LINE))) begin
                hit = 4'(k);
            end
        end
        return hit;
    endfunction

    pin_sync #(.WIDTH(flex_line_pkg::LINE_COUNT)) u_pin_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pin(line_in),
        .synced(line_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // access decode and next values

    assign single_line = line_of(reg_addr, flex_line_pkg::ADDR_SINGLE,
                                 flex_line_pkg::STRIDE_SINGLE); // see RULE5
    assign analog_line = line_of(reg_addr, flex_line_pkg::ADDR_ANALOG,
                                 flex_line_pkg::STRIDE_ANALOG);
    // bit n of the mask guards channel n
    assign allow = ~write_block[flex_line_pkg::LAST_LINE:flex_line_pkg::FIRST_LINE]; // see RULE10
    // a write in the same cycle wins; the read is dropped with no answer
    assign rd_only = reg_rd && !reg_wr;

    always_comb begin
        next_analog = analog;
        next_dir = dir;
        next_level = level;
        next_pullup_off = pullup_off;
        next_write_block = write_block;
        next_rdata = 32'h0000_0000;
        next_rvalid = 1'b0;
        next_adc_channel = adc_channel;
        next_adc_start = 1'b0;
        if (reg_wr) begin
            if (reg_addr == flex_line_pkg::ADDR_STATE) begin
                // direction untouched, blocked bits kept
                next_level = (level & ~allow) | (reg_wdata[11:4] & allow); // see RULE9 RULE17
            end else if (reg_addr == flex_line_pkg::ADDR_DIRECTION) begin
                next_dir = (dir & ~allow) | (reg_wdata[11:4] & allow); // see RULE8 RULE6
            end else if (reg_addr == flex_line_pkg::ADDR_ANALOG_SELECT) begin
                next_analog = (analog & ~allow) | (reg_wdata[11:4] & allow); // see RULE7 RULE6
                next_dir = dir & ~(analog & ~next_analog); // see RULE7
            end else if (reg_addr == flex_line_pkg::ADDR_PULLUP_OFF) begin
                next_pullup_off = reg_wdata[11:0]; // see RULE12
            end else if (reg_addr == flex_line_pkg::ADDR_WRITE_BLOCK) begin
                next_write_block = reg_wdata;
            end else if (single_line != flex_line_pkg::NO_LINE) begin
                // an analog line ignores the write
                if (!analog[single_line]) begin // see RULE3
                    next_dir[single_line] = 1'b1; // see RULE2
                    next_level[single_line] = reg_wdata[0];
                end
            end
        end else if (rd_only) begin
            next_rvalid = 1'b1;
            if (reg_addr == flex_line_pkg::ADDR_STATE) begin
                // sensed terminal level, not the latch
                next_rdata[11:4] = line_sync; // see RULE9
            end else if (reg_addr == flex_line_pkg::ADDR_DIRECTION) begin
                next_rdata[11:4] = dir;
            end else if (reg_addr == flex_line_pkg::ADDR_ANALOG_SELECT) begin
                next_rdata[11:4] = analog;
            end else if (reg_addr == flex_line_pkg::ADDR_PULLUP_OFF) begin
                next_rdata[11:0] = pullup_off;
            end else if (reg_addr == flex_line_pkg::ADDR_WRITE_BLOCK) begin
                next_rdata = write_block;
            end else if (single_line != flex_line_pkg::NO_LINE) begin
                next_analog[single_line] = 1'b0; // see RULE1
                next_dir[single_line] = 1'b0;
                next_rdata[0] = line_sync[single_line];
            end else if (analog_line != flex_line_pkg::NO_LINE) begin
                // value is the converter's latest result; conversion runs outside
                next_analog[analog_line] = 1'b1; // see RULE4
                next_adc_channel = analog_line;
                next_adc_start = 1'b1;
                next_rdata = adc_value;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            analog <= flex_line_pkg::LINES_RESET;
            dir <= flex_line_pkg::LINES_RESET;
            level <= flex_line_pkg::LINES_RESET;
            pullup_off <= flex_line_pkg::PULLUP_RESET;
            write_block <= flex_line_pkg::WRITE_BLOCK_RESET;
            reg_rdata <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
            adc_channel <= flex_line_pkg::NO_LINE;
            adc_start <= 1'b0;
        end else begin
            analog <= next_analog;
            dir <= next_dir;
            level <= next_level;
            pullup_off <= next_pullup_off;
            write_block <= next_write_block;
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
            adc_channel <= next_adc_channel;
            adc_start <= next_adc_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins and per-line checks

    assign line_out = level;

    for (genvar g = flex_line_pkg::FIRST_LINE; g <= flex_line_pkg::LAST_LINE; g++) begin : g_line
        localparam logic [15:0] SINGLE_AT = 16'(flex_line_pkg::ADDR_SINGLE
            + flex_line_pkg::STRIDE_SINGLE * 16'(g - flex_line_pkg::FIRST_LINE));
        localparam logic [15:0] ANALOG_AT = 16'(flex_line_pkg::ADDR_ANALOG
            + flex_line_pkg::STRIDE_ANALOG * 16'(g - flex_line_pkg::FIRST_LINE));

        // drive only a digital output; an analog sensor must not be driven
        assign line_oe[g] = dir[g] && !analog[g];
        assign pullup_en[g] = !analog[g] && !dir[g] && !pullup_off[g]; // see RULE11

        a_read_sets_input: assert property (@(posedge clock) disable iff (!reset_n) // see RULE1
            (rd_only && reg_addr == SINGLE_AT) |=> !analog[g] && !dir[g] && reg_rvalid
            && reg_rdata[0] == $past(line_sync[g]))
            else $error("single read did not make an input");
        a_write_drives: assert property (@(posedge clock) disable iff (!reset_n) // see RULE2
            (reg_wr && reg_addr == SINGLE_AT && !analog[g])
            |=> line_oe[g] && line_out[g] == $past(reg_wdata[0]))
            else $error("single write did not drive");
        a_analog_ignores: assert property (@(posedge clock) disable iff (!reset_n) // see RULE3
            (reg_wr && reg_addr == SINGLE_AT && analog[g])
            |=> analog[g] && !line_oe[g] && $stable(level[g]))
            else $error("analog line took a single write");
        a_ain_selects: assert property (@(posedge clock) disable iff (!reset_n) // see RULE4
            (rd_only && reg_addr == ANALOG_AT) |=> analog[g] && adc_start
            && adc_channel == 4'(g) && !line_oe[g])
            else $error("analog read did not select analog");
        a_block_holds: assert property (@(posedge clock) disable iff (!reset_n) // see RULE6
            (reg_wr && write_block[g] && (reg_addr == flex_line_pkg::ADDR_STATE
            || reg_addr == flex_line_pkg::ADDR_DIRECTION
            || reg_addr == flex_line_pkg::ADDR_ANALOG_SELECT))
            |=> $stable(level[g]) && $stable(dir[g]) && $stable(analog[g]))
            else $error("blocked bit changed");
        a_leave_analog: assert property (@(posedge clock) disable iff (!reset_n) // see RULE7
            (reg_wr && reg_addr == flex_line_pkg::ADDR_ANALOG_SELECT && !write_block[g]
            && analog[g] && !reg_wdata[g]) |=> !analog[g] && !dir[g] && !line_oe[g])
            else $error("leaving analog did not give an input");
        a_dir_takes: assert property (@(posedge clock) disable iff (!reset_n) // see RULE8
            (reg_wr && reg_addr == flex_line_pkg::ADDR_DIRECTION && !write_block[g])
            |=> dir[g] == $past(reg_wdata[g]) && $stable(analog[g]))
            else $error("direction write lost");
        a_state_keeps_dir: assert property (@(posedge clock) disable iff (!reset_n) // see RULE9
            (reg_wr && reg_addr == flex_line_pkg::ADDR_STATE && !write_block[g])
            |=> level[g] == $past(reg_wdata[g]) && $stable(dir[g]))
            else $error("state write touched direction");
        a_pullup_gate: assert property (@(posedge clock) disable iff (!reset_n) // see RULE11
            $rose(pullup_off[g]) |-> !pullup_en[g] && $past(reg_wr))
            else $error("pull-up on while disabled");
    end

    a_pullup_free: assert property (@(posedge clock) disable iff (!reset_n) // see RULE12
        (reg_wr && reg_addr == flex_line_pkg::ADDR_PULLUP_OFF)
        |=> pullup_off == $past(reg_wdata[11:0]))
        else $error("pull-up-off write filtered");
    a_state_read: assert property (@(posedge clock) disable iff (!reset_n) // see RULE9
        (rd_only && reg_addr == flex_line_pkg::ADDR_STATE)
        |=> reg_rvalid && reg_rdata[11:4] == $past(line_sync) && reg_rdata[3:0] == 4'h0)
        else $error("state read wrong");
endmodule

// [test/line_pins.sv]
// Purpose: pins of the eight flexible lines with the outside circuits on them
// Assumes: the bench may drive any line from outside through ext_en and ext_level
// Notes: an undriven line with its pull-up off floats to the inverse of its latch
`timescale 1ns/1ps
module line_pins (
    input wire logic [11:4] line_out,
    input wire logic [11:4] line_oe,
    input wire logic [11:4] pullup_en,
    input wire logic [11:4] ext_en,
    input wire logic [11:4] ext_level,
    output logic [11:4] line_in
);
    ////////////////////////////////////////////////////////////////////////////
    // the device output wins over the outside driver, as the series resistor is
    // read behind; a floating pin must not look like a clean copy of the latch
    always_comb begin
        for (int i = 4; i <= 11; i++) begin
            if (line_oe[i])
                line_in[i] = line_out[i];
            else if (ext_en[i])
                line_in[i] = ext_level[i];
            else if (pullup_en[i])
                line_in[i] = 1'b1;
            else
                line_in[i] = ~line_out[i];
        end
    end
endmodule

// [test/flexible_io_line_config_tb.sv]
// Purpose: self-checking bench for the flexible line configuration block
// Assumes: pins settle through the two-flop synchroniser within three cycles
// Notes: each scenario starts from a fresh reset so expectations stay local
`timescale 1ns/1ps
module flexible_io_line_config_tb;
    logic clock, reset_n, reg_wr, reg_rd, reg_rvalid, adc_start;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, adc_value, rdat;
    logic [3:0] adc_channel;
    logic [11:4] line_in, line_out, line_oe, pullup_en, ext_en, ext_level;
    int bad_count = 0;
    int cmp_count = 0;

    flexible_io_line_config dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .adc_value(adc_value), .adc_channel(adc_channel),
        .adc_start(adc_start), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
        .pullup_en(pullup_en));
    line_pins pins (.line_out(line_out), .line_oe(line_oe), .pullup_en(pullup_en),
        .ext_en(ext_en), .ext_level(ext_level), .line_in(line_in));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    // bounded wait on the answer strobe; a lost answer ends the run
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        int n;
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        n = 0;
        #1;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 4) begin
            bad_count++;
            give_verdict();
        end else begin
            d = reg_rdata;
        end
    endtask
    task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
        rd(a, rdat);
        chk(rdat, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        chk({24'h0, pullup_en}, 32'h0000_00ff);
        rchk(flex_line_pkg::ADDR_WRITE_BLOCK, 32'h0000_0000);
        rchk(flex_line_pkg::ADDR_DIRECTION, 32'h0000_0000);
        rchk(16'h0009, 32'h0000_0000);
    endtask
    task automatic s_single_read();
        do_reset();
        ext_en <= 8'h02;
        wr(flex_line_pkg::ADDR_SINGLE + 16'h0001, 32'h1);
        repeat (3) @(posedge clock);
        rchk(flex_line_pkg::ADDR_SINGLE + 16'h0001, 32'h1);
        chk({24'h0, line_oe}, 32'h0);
        repeat (3) @(posedge clock);
        rchk(flex_line_pkg::ADDR_SINGLE + 16'h0001, 32'h0);
        rchk(flex_line_pkg::ADDR_SINGLE + 16'h0002, 32'h1);
        ext_en <= 8'h00;
    endtask
    task automatic s_single_write();
        do_reset();
        wr(flex_line_pkg::ADDR_SINGLE, 32'h1);
        wr(flex_line_pkg::ADDR_SINGLE + 16'h0007, 32'h1);
        chk({24'h0, line_oe}, 32'h81);
        wr(flex_line_pkg::ADDR_SINGLE, 32'h0);
        chk({24'h0, line_out}, 32'h80);
        repeat (3) @(posedge clock);
        rchk(flex_line_pkg::ADDR_STATE, 32'h0000_0fe0);
        rchk(flex_line_pkg::ADDR_DIRECTION, 32'h0000_0810);
        wr(flex_line_pkg::ADDR_STATE, 32'h0000_0010);
        chk({24'h0, line_out}, 32'h01);
        chk({24'h0, line_oe}, 32'h81);
    endtask
    task automatic s_analog();
        do_reset();
        wr(flex_line_pkg::ADDR_ANALOG_SELECT, 32'h0000_0100);
        rchk(flex_line_pkg::ADDR_ANALOG + 16'h000a, adc_value);
        chk({28'h0, adc_channel}, 32'h9);
        chk({31'h0, adc_start}, 32'h1);
        rchk(flex_line_pkg::ADDR_ANALOG_SELECT, 32'h0000_0300);
        chk({24'h0, pullup_en}, 32'hcf);
        wr(flex_line_pkg::ADDR_SINGLE + 16'h0005, 32'h1);
        chk({24'h0, line_oe}, 32'h0);
        rchk(flex_line_pkg::ADDR_ANALOG_SELECT, 32'h0000_0300);
        rd(flex_line_pkg::ADDR_SINGLE + 16'h0005, rdat);
        wr(flex_line_pkg::ADDR_SINGLE + 16'h0005, 32'h1);
        chk({24'h0, line_oe}, 32'h20);
        wr(flex_line_pkg::ADDR_DIRECTION, 32'h0000_0300);
        wr(flex_line_pkg::ADDR_ANALOG_SELECT, 32'h0000_0000);
        rchk(flex_line_pkg::ADDR_DIRECTION, 32'h0000_0200);
    endtask
    task automatic s_inhibit();
        do_reset();
        wr(flex_line_pkg::ADDR_WRITE_BLOCK, 32'h0000_0ff0);
        wr(flex_line_pkg::ADDR_PULLUP_OFF, 32'h0000_00a0);
        chk({24'h0, pullup_en}, 32'hf5);
        wr(flex_line_pkg::ADDR_WRITE_BLOCK, 32'h0000_0fc0);
        wr(flex_line_pkg::ADDR_DIRECTION, 32'h0000_0ff0);
        rchk(flex_line_pkg::ADDR_DIRECTION, 32'h0000_0030);
        chk({24'h0, line_oe}, 32'h03);
        chk({24'h0, pullup_en}, 32'hf4);
        wr(flex_line_pkg::ADDR_STATE, 32'h0000_0ff0);
        chk({24'h0, line_out}, 32'h03);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0;
        adc_value = 32'h40a0_0000;
        ext_en = 8'h00;
        ext_level = 8'h00;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        s_reset();
        s_single_read();
        s_single_write();
        s_analog();
        s_inhibit();
        give_verdict();
    end
endmodule
